// ### rtl/wdt_lfsr.sv
// Sequence register that produces the expected service values
`timescale 1ns/1ns
`default_nettype none
module wdt_lfsr
	import wdt_pkg::*;
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic seed_load,
	input wire logic [7:0] seed,
	input wire logic advance,
	output logic [7:0] expected
);

	typedef struct packed {
		logic [7:0] seq;
	} wdt_lfsr_state_t;

	wdt_lfsr_state_t st_q;
	wdt_lfsr_state_t st_d;

	// Left shift with taps folded back; reproduces AA, 37, 6E, DC
	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		lfsr_next = {s[6:0], 1'b0} ^ (s[7] ? LFSR_TAPS : 8'h00);
	endfunction

	always_comb begin
		st_d = st_q;
		if (seed_load) begin
			st_d.seq = seed;
		end else if (advance) begin
			st_d.seq = lfsr_next(st_q.seq);
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= '{seq: LFSR_RESET};
		end else begin
			st_q <= st_d;
		end
	end

	assign expected = st_q.seq;

	property p_advance;
		@(posedge mclk) disable iff (!reset_n)
		(advance && !seed_load) |=> (expected == lfsr_next($past(expected)));
	endproperty
	a_advance: assert property (p_advance) else $error("bad step");

endmodule
`default_nettype wire

// ### rtl/wdt_pkg.sv
// Package: constants and types of the watchdog-capable timer
package wdt_pkg;

	// ------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------
	localparam logic [31:0] ADDR_RELOAD_VALUE = 32'hFFFF0360;
	localparam logic [31:0] ADDR_CURRENT_COUNT = 32'hFFFF0364;
	localparam logic [31:0] ADDR_TIMER_TWO_CONTROL = 32'hFFFF0368;
	localparam logic [31:0] ADDR_WATCHDOG_SERVICE = 32'hFFFF036C;
	localparam logic [31:0] ADDR_IRQ_STATUS = 32'hFFFF0370;
	localparam logic [31:0] ADDR_IRQ_MASK = 32'hFFFF0374;

	// ------------------------------------------------------------
	// Control field positions and reset values
	// ------------------------------------------------------------
	localparam int CTL_COUNT_UP = 8;
	localparam int CTL_ENABLE = 7;
	localparam int CTL_PERIODIC = 6;
	localparam int CTL_WDOG = 5;
	localparam int CTL_SECURE = 4;
	localparam int CTL_PRESC_HI = 3;
	localparam int CTL_PRESC_LO = 2;
	localparam int CTL_IRQ_OPT = 1;
	localparam logic [15:0] CTL_WRITE_MASK = 16'h01FE;
	localparam logic [15:0] CTL_RESET = 16'h0000;
	localparam logic [15:0] RELOAD_RESET = 16'h0000;
	localparam logic [15:0] COUNT_RESET = 16'hFFFF;
	localparam logic [15:0] COUNT_FULL = 16'hFFFF;
	localparam logic [15:0] COUNT_ZERO = 16'h0000;

	// Prescale selections
	localparam logic [1:0] PRESC_DIV1 = 2'h0;
	localparam logic [1:0] PRESC_DIV16 = 2'h1;
	localparam logic [1:0] PRESC_DIV256 = 2'h2;
	localparam logic [7:0] PRESC_LAST16 = 8'h0F;
	localparam logic [7:0] PRESC_LAST256 = 8'hFF;

	// Interrupt status bits
	localparam int IRQ_TIMEOUT = 0;
	localparam int IRQ_SERVICED = 1;
	localparam int IRQ_BITS = 2;

	// ------------------------------------------------------------
	// Sequence register
	// ------------------------------------------------------------
	localparam logic [7:0] LFSR_TAPS = 8'h63;
	localparam logic [7:0] LFSR_RESET = 8'h00;
	localparam logic [7:0] SVC_FORBIDDEN = 8'h00;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int MCLK_HZ = 10_000_000;
	localparam int SRC_CLK_HZ = 32_768;
	localparam int SRC_TICK_CYC = MCLK_HZ / SRC_CLK_HZ;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic wr;
		logic rd;
		logic [31:0] addr;
		logic [31:0] wdata;
	} wdt_bus_req_t;

	typedef enum logic [1:0] {
		WDT_OFF = 2'b00,
		WDT_RUN = 2'b01,
		WDT_WATCH = 2'b11,
		WDT_TRIP = 2'b10
	} wdt_mode_t;

endpackage

// ### rtl/wdt_timer.sv
// Watchdog-capable timer with secure clear, top level
//
// Summary of operation
// - Control bit 8 set counts up; clear (default) counts down.
// - Control bit 7 enables counting outside watchdog mode; cleared by default, timer holds unless bit 5 is set.
// - Bit 1 chooses interrupt instead of chip reset at watchdog expiry.
// - Outside watchdog mode a service write clears the timer interrupt; an accepted one in watchdog mode restarts the timeout.
// - Under secure clear only the expected sequence byte is accepted.
// - Expected values come from an 8-bit LFSR, x^8+x^6+x^5+x+1.
// - Service byte written before watchdog mode seeds the sequence.
// - A matching service write reloads the counter and steps the sequence.
// - A mismatching secure write resets the chip at once.
// - A zero byte always forces reset under secure clear; never seed zero.
// - The sequence register cannot be read back by software.
// - Watchdog mode starts by setting bit 5, after writing the reload.
// - Watchdog counts down from the current count; accepted service reloads counter.
// - In watchdog mode reload and control registers ignore writes.
// - Control bit 4 enables secure clear; off by default.
//
// The strobed register port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module wdt_timer
	import wdt_pkg::*;
#(
	parameter int CLK_HZ = MCLK_HZ,
	parameter int SRC_HZ = SRC_CLK_HZ
)(
	input wire logic mclk,
	input wire logic reset_n,
	input wire wdt_bus_req_t bus_req,
	output logic [31:0] bus_rdata,
	output logic irq,
	output logic chip_reset_req
);

	// ------------------------------------------------------------
	// Elaboration checks and derived counts
	// ------------------------------------------------------------
	localparam int TICK_CYC = CLK_HZ / SRC_HZ;
	localparam int DIV_W = $clog2(TICK_CYC + 1);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYC - 1);

	if (TICK_CYC < 1) begin : g_bad_rate
		$error("source clock faster than mclk");
	end

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [15:0] reload;
		logic [15:0] count;
		logic [15:0] ctrl;
		logic [IRQ_BITS-1:0] status;
		logic [IRQ_BITS-1:0] mask;
		logic [DIV_W-1:0] div;
		logic [7:0] pre;
		logic [31:0] rdata;
		logic irq;
		logic trip;
		wdt_mode_t mode;
	} wdt_state_t;

	wdt_state_t st_q;
	wdt_state_t st_d;

	logic [7:0] expected;
	logic svc_wr;
	logic [7:0] svc_byte;
	logic watching;
	logic secure;
	logic accepted;
	logic src_tick;
	logic tick;
	logic at_end;
	logic lfsr_seed;
	logic lfsr_step;

	// ------------------------------------------------------------
	// Service write decode
	// ------------------------------------------------------------
	assign svc_wr = bus_req.wr && (bus_req.addr == ADDR_WATCHDOG_SERVICE);
	assign svc_byte = bus_req.wdata[7:0];
	assign watching = st_q.ctrl[CTL_WDOG];
	assign secure = st_q.ctrl[CTL_SECURE];
	// Zero never matches: a zero seed would otherwise lock the sequence
	assign accepted = watching && svc_wr && (!secure ||
		(svc_byte == expected && svc_byte != SVC_FORBIDDEN));
	assign lfsr_seed = svc_wr && !watching;
	assign lfsr_step = accepted && secure;

	// Sequence value stays internal; no read path exists
	wdt_lfsr u_lfsr (
		.mclk(mclk),
		.reset_n(reset_n),
		.seed_load(lfsr_seed),
		.seed(svc_byte),
		.advance(lfsr_step),
		.expected(expected)
	);

	// ------------------------------------------------------------
	// Time base
	// ------------------------------------------------------------
	assign src_tick = (st_q.div == DIV_LAST);

	always_comb begin
		unique case (st_q.ctrl[CTL_PRESC_HI:CTL_PRESC_LO])
			PRESC_DIV16: tick = src_tick && (st_q.pre[3:0] == PRESC_LAST16[3:0]);
			PRESC_DIV256: tick = src_tick && (st_q.pre == PRESC_LAST256);
			default: tick = src_tick;
		endcase
	end

	assign at_end = (st_q.ctrl[CTL_COUNT_UP] && !watching) ?
		(st_q.count == COUNT_FULL) : (st_q.count == COUNT_ZERO);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.div = src_tick ? '0 : st_q.div + DIV_W'(1);
		if (src_tick) begin
			st_d.pre = st_q.pre + 8'h01;
		end

		// Register writes; reload and control locked once watchdog mode is on
		if (bus_req.wr && !watching) begin
			if (bus_req.addr == ADDR_RELOAD_VALUE) begin
				st_d.reload = bus_req.wdata[15:0];
			end
			if (bus_req.addr == ADDR_TIMER_TWO_CONTROL) begin
				st_d.ctrl = bus_req.wdata[15:0] & CTL_WRITE_MASK;
			end
		end
		if (bus_req.wr && bus_req.addr == ADDR_IRQ_MASK) begin
			st_d.mask = bus_req.wdata[IRQ_BITS-1:0];
		end

		// Read clears status; events below still win
		if (bus_req.rd && bus_req.addr == ADDR_IRQ_STATUS) begin
			st_d.status = '0;
		end
		if (svc_wr && !watching) begin
			st_d.status[IRQ_TIMEOUT] = 1'b0;
		end

		// Counting
		unique case (st_q.mode)
			WDT_RUN: begin
				if (tick) begin
					if (at_end) begin
						st_d.status[IRQ_TIMEOUT] = 1'b1;
						if (st_q.ctrl[CTL_PERIODIC]) begin
							st_d.count = st_q.reload;
						end else begin
							st_d.count = st_q.ctrl[CTL_COUNT_UP] ?
								COUNT_ZERO : COUNT_FULL;
						end
					end else if (st_q.ctrl[CTL_COUNT_UP]) begin
						st_d.count = st_q.count + 16'h0001;
					end else begin
						st_d.count = st_q.count - 16'h0001;
					end
				end
			end
			WDT_WATCH: begin
				if (tick) begin
					if (at_end) begin
						if (st_q.ctrl[CTL_IRQ_OPT]) begin
							st_d.status[IRQ_TIMEOUT] = 1'b1;
							st_d.count = st_q.reload;
						end else begin
							st_d.trip = 1'b1;
						end
					end else begin
						st_d.count = st_q.count - 16'h0001;
					end
				end
			end
			default: begin
				st_d.count = st_q.count;
			end
		endcase

		// Service write restarts the timeout or trips the chip
		if (accepted) begin
			st_d.count = st_q.reload;
			st_d.status[IRQ_SERVICED] = 1'b1;
		end else if (watching && svc_wr) begin
			st_d.trip = 1'b1;
		end

		// Mode follows control; trip holds until reset
		if (st_d.trip) begin
			st_d.mode = WDT_TRIP;
		end else if (st_d.ctrl[CTL_WDOG]) begin
			st_d.mode = WDT_WATCH;
		end else if (st_d.ctrl[CTL_ENABLE]) begin
			st_d.mode = WDT_RUN;
		end else begin
			st_d.mode = WDT_OFF;
		end

		st_d.irq = |(st_d.status & st_d.mask);

		// Read data valid only the cycle after the strobe
		st_d.rdata = 32'h00000000;
		if (bus_req.rd) begin
			unique case (bus_req.addr)
				ADDR_RELOAD_VALUE: st_d.rdata = {16'h0000, st_q.reload};
				ADDR_CURRENT_COUNT: st_d.rdata = {16'h0000, st_q.count};
				ADDR_TIMER_TWO_CONTROL: st_d.rdata = {16'h0000, st_q.ctrl};
				ADDR_IRQ_STATUS: st_d.rdata = {30'h0, st_q.status};
				ADDR_IRQ_MASK: st_d.rdata = {30'h0, st_q.mask};
				default: st_d.rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= '{reload: RELOAD_RESET, count: COUNT_RESET,
				ctrl: CTL_RESET, status: '0, mask: '0, div: '0,
				pre: 8'h00, rdata: 32'h00000000, irq: 1'b0,
				trip: 1'b0, mode: WDT_OFF};
		end else begin
			st_q <= st_d;
		end
	end

	assign bus_rdata = st_q.rdata;
	assign irq = st_q.irq;
	assign chip_reset_req = st_q.trip;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_lock;
		@(posedge mclk) disable iff (!reset_n)
		(watching && bus_req.wr) |=> $stable(st_q.ctrl) && $stable(st_q.reload);
	endproperty
	a_lock: assert property (p_lock) else $error("locked reg changed");

	property p_direction;
		@(posedge mclk) disable iff (!reset_n)
		(st_q.mode == WDT_RUN && tick && !at_end && !svc_wr) |=>
		(st_q.count == ($past(st_q.ctrl[CTL_COUNT_UP]) ?
			$past(st_q.count) + 16'h0001 : $past(st_q.count) - 16'h0001));
	endproperty
	a_direction: assert property (p_direction) else $error("bad step");

	property p_disabled;
		@(posedge mclk) disable iff (!reset_n)
		(st_q.mode == WDT_OFF && !svc_wr) |=> $stable(st_q.count);
	endproperty
	a_disabled: assert property (p_disabled) else $error("count moved");

	property p_expire_reset;
		@(posedge mclk) disable iff (!reset_n)
		(st_q.mode == WDT_WATCH && tick && at_end && !st_q.ctrl[CTL_IRQ_OPT])
		|=> chip_reset_req;
	endproperty
	a_expire_reset: assert property (p_expire_reset) else $error("missed");

	property p_expire_irq;
		@(posedge mclk) disable iff (!reset_n)
		(st_q.mode == WDT_WATCH && tick && at_end && st_q.ctrl[CTL_IRQ_OPT]
		&& !svc_wr) |=> st_q.status[IRQ_TIMEOUT] && !chip_reset_req;
	endproperty
	a_expire_irq: assert property (p_expire_irq) else $error("no irq");

	property p_mismatch;
		@(posedge mclk) disable iff (!reset_n)
		(watching && secure && svc_wr && svc_byte != expected) |=> chip_reset_req;
	endproperty
	a_mismatch: assert property (p_mismatch) else $error("bad byte kept");

	property p_reload;
		@(posedge mclk) disable iff (!reset_n)
		accepted |=> (st_q.count == $past(st_q.reload)) && !chip_reset_req;
	endproperty
	a_reload: assert property (p_reload) else $error("no reload");

	property p_seed;
		@(posedge mclk) disable iff (!reset_n)
		lfsr_seed |=> (expected == $past(svc_byte));
	endproperty
	a_seed: assert property (p_seed) else $error("seed not taken");

	property p_irq_out;
		@(posedge mclk) disable iff (!reset_n)
		(st_q.status[IRQ_TIMEOUT] && st_q.mask[IRQ_TIMEOUT]) |-> irq;
	endproperty
	a_irq_out: assert property (p_irq_out) else $error("irq low");

endmodule
`default_nettype wire

// ### sim/wdt_timer_test.sv
// Self-checking bench of the watchdog-capable timer
`timescale 1ns/1ns
`default_nettype none
module wdt_timer_test
	import wdt_pkg::*;
;
	// ----------------------------------------
	// Bench state
	// ----------------------------------------
	localparam logic [31:0] A_LD = ADDR_RELOAD_VALUE;
	localparam logic [31:0] A_CNT = ADDR_CURRENT_COUNT;
	localparam logic [31:0] A_CTL = ADDR_TIMER_TWO_CONTROL;
	localparam logic [31:0] A_SVC = ADDR_WATCHDOG_SERVICE;
	localparam logic [31:0] A_ST = ADDR_IRQ_STATUS;
	localparam logic [31:0] A_MSK = ADDR_IRQ_MASK;
	logic mclk;
	logic reset_n;
	wdt_bus_req_t bus_req;
	logic [31:0] bus_rdata;
	logic irq;
	logic chip_reset_req;
	logic [31:0] rv;
	logic [15:0] c0;
	logic [15:0] rnd;
	logic [7:0] seq;
	int n_mismatch;
	int compares;

	// Source clock at half of mclk keeps every period short
	wdt_timer #(.CLK_HZ(MCLK_HZ), .SRC_HZ(MCLK_HZ / 2)) u_dut (
		.mclk(mclk),
		.reset_n(reset_n),
		.bus_req(bus_req),
		.bus_rdata(bus_rdata),
		.irq(irq),
		.chip_reset_req(chip_reset_req)
	);

	always #50 mclk = ~mclk;

	// ----------------------------------------
	// Shared tasks and the sequence model
	// ----------------------------------------
	function automatic logic [7:0] seq_next(input logic [7:0] s);
		return {s[6:0], 1'b0} ^ (s[7] ? 8'h63 : 8'h00);
	endfunction

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge mclk);
		bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge mclk);
		bus_req.wr <= 1'b0;
		#1;
	endtask

	// Read data stand only in the cycle after the strobe edge
	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		@(posedge mclk);
		bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(posedge mclk);
		bus_req.rd <= 1'b0;
		#1;
		d = bus_rdata;
	endtask

	task automatic chk_rd(input string nm, input logic [31:0] a,
		input logic [31:0] e);
		rd(a, rv);
		chk(nm, e, rv);
	endtask

	task automatic do_reset();
		@(posedge mclk);
		reset_n <= 1'b0;
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
	endtask

	// Bounded wait; running out ends the run
	task automatic wait_hi(input string nm, input bit use_irq,
		input int bound);
		int n;
		n = 0;
		while (((use_irq ? irq : chip_reset_req) !== 1'b1) && n < bound) begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk(nm, 32'h1, {31'h0, n < bound});
		if (n >= bound) begin
			end_sim();
		end
	endtask

	// Count must move lo..hi steps in the given direction over 20 cycles
	task automatic cnt(input string nm, input bit up, input int lo,
		input int hi);
		logic [15:0] d;
		rd(A_CNT, rv);
		c0 = rv[15:0];
		repeat (20) @(posedge mclk);
		rd(A_CNT, rv);
		d = up ? rv[15:0] - c0 : c0 - rv[15:0];
		chk(nm, 32'h1, {31'h0, d >= lo && d <= hi});
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		reset_n = 1'b0;
		bus_req = '0;
		n_mismatch = 0;
		compares = 0;
		void'($urandom(32'hBC392BFA));
		repeat (20) @(posedge mclk);
		reset_n <= 1'b1;
		chk_rd("reload", A_LD, 32'h0);
		chk_rd("count", A_CNT, 32'hFFFF);
		chk_rd("control", A_CTL, 32'h0);
		chk_rd("status", A_ST, 32'h0);
		chk_rd("mask", A_MSK, 32'h0);
		chk_rd("service", A_SVC, 32'h0);
		chk_rd("unmapped", 32'hFFFF0378, 32'h0);
		wr(A_CNT, 32'h1234);
		chk_rd("count ro", A_CNT, 32'hFFFF);
		// Watchdog bit kept clear so the lock is not entered here
		rnd = 16'($urandom()) & 16'hFFDF;
		wr(A_CTL, {16'h0, rnd});
		chk_rd("control rw", A_CTL, {16'h0, rnd & 16'h01FE});
		wr(A_CTL, 32'h0);
		cnt("hold", 1'b0, 0, 0);
		wr(A_CTL, 32'h0080);
		cnt("down", 1'b0, 9, 13);
		wr(A_CTL, 32'h0180);
		cnt("up", 1'b1, 9, 13);
		// Prescale code 11 runs like /1; /16 and /256 barely move
		wr(A_CTL, 32'h008C);
		cnt("presc 11", 1'b0, 9, 13);
		wr(A_CTL, 32'h0084);
		cnt("div16", 1'b0, 0, 1);
		wr(A_CTL, 32'h0088);
		cnt("div256", 1'b0, 0, 1);
		$display("Test registers and direction done");
		// Periodic up count reloads at full scale and raises the flag
		do_reset();
		wr(A_MSK, 32'h1);
		wr(A_LD, 32'hFFF0);
		wr(A_CTL, 32'h01C0);
		wait_hi("wrap irq", 1'b1, 20);
		wr(A_CTL, 32'h0);
		rd(A_CNT, rv);
		chk("periodic", 32'h1, {31'h0, rv >= 32'hFFF0 && rv <= 32'hFFF2});
		wr(A_SVC, 32'h3C);
		@(posedge mclk);
		#1;
		chk("irq ack", 32'h0, {31'h0, irq});
		$display("Test normal acknowledge done");
		// Secure clear with the model tracking the sequence
		do_reset();
		wr(A_LD, 32'h0040);
		seq = 8'hAA;
		wr(A_SVC, {24'h0, seq});
		wr(A_MSK, 32'h2);
		wr(A_CTL, 32'h00B0);
		for (int i = 0; i < 4; i++) begin
			wr(A_SVC, {24'h0, seq});
			chk("no trip", 32'h0, {31'h0, chip_reset_req});
			rd(A_CNT, rv);
			chk("reload", 32'h1, {31'h0, rv <= 32'h40 && rv >= 32'h3D});
			seq = seq_next(seq);
			repeat (30) @(posedge mclk);
		end
		#1;
		chk("svc irq", 32'h1, {31'h0, irq});
		chk_rd("svc status", A_ST, 32'h2);
		@(posedge mclk);
		#1;
		chk("irq cleared", 32'h0, {31'h0, irq});
		wr(A_LD, 32'h1234);
		wr(A_CTL, 32'h0);
		chk_rd("ld locked", A_LD, 32'h0040);
		chk_rd("ctl locked", A_CTL, 32'h00B0);
		wr(A_SVC, {24'h0, seq ^ 8'(1 + $urandom() % 255)});
		chk("bad svc", 32'h1, {31'h0, chip_reset_req});
		$display("Test secure clear done");
		// A zero byte trips even when it is the expected value
		do_reset();
		wr(A_LD, 32'h0040);
		// Zero seed makes zero the expected byte
		wr(A_SVC, 32'h00);
		wr(A_CTL, 32'h00B0);
		wr(A_SVC, 32'h00);
		chk("zero svc", 32'h1, {31'h0, chip_reset_req});
		// Expiry without irq option resets the chip
		do_reset();
		wr(A_LD, 32'h0004);
		wr(A_CTL, 32'h00A0);
		wr(A_SVC, 32'h55);
		chk("early", 32'h0, {31'h0, chip_reset_req});
		wait_hi("expiry", 1'b0, 30);
		// Expiry with irq option raises the interrupt instead
		do_reset();
		wr(A_LD, 32'h0004);
		wr(A_CTL, 32'h00A2);
		wr(A_SVC, 32'h11);
		repeat (30) @(posedge mclk);
		#1;
		chk("masked", 32'h0, {30'h0, irq, chip_reset_req});
		rd(A_ST, rv);
		chk("timeout", 32'h1, {31'h0, rv[0]});
		wr(A_MSK, 32'h1);
		wait_hi("wd irq", 1'b1, 30);
		wr(A_MSK, 32'h0);
		@(posedge mclk);
		#1;
		chk("unmask", 32'h0, {31'h0, irq});
		$display("Test expiry done");
		end_sim();
	end
endmodule
`default_nettype wire
